// >>> common/rssx_defs.svh
`ifndef RSSX_DEFS_SVH
`define RSSX_DEFS_SVH

// operand layout
`define RSSX_BYTE_MSB 7
`define RSSX_NIB_MSB 3
`define RSSX_DEC_STEP 8'h01
`define RSSX_ZERO_BYTE 8'h00

// reset values of the registered outputs
`define RSSX_RST_BYTE 8'h00
`define RSSX_RST_FLAG 1'b0
`define RSSX_RST_READY 1'b1

// the skip costs this many cycles beyond the instruction
`define RSSX_DUMMY_CYCLES 1

`endif

// >>> common/rssx_pkg.sv
package rssx_pkg;

  typedef enum logic [2:0] {
    RSSX_OP_ROTATE = 3'h0,
    RSSX_OP_SUB_MEM = 3'h1,
    RSSX_OP_SUB_IMM = 3'h2,
    RSSX_OP_SUB_TO_MEM = 3'h3,
    RSSX_OP_DEC_SKIP = 3'h4,
    RSSX_OP_DEC_SKIP_WORK = 3'h5
  } rssx_op_e;

  typedef enum logic [0:0] {
    RSSX_ST_RUN = 1'b0,
    RSSX_ST_DUMMY = 1'b1
  } rssx_state_e;

  typedef struct packed {
    logic overflow_flag;
    logic zero_flag;
    logic half_carry_flag;
    logic carry_flag;
    logic signed_compare_flag;
    logic chained_zero_flag;
  } rssx_flags_s;

endpackage

// >>> common/rssx_alu_if.sv
`timescale 1ns/1ps
interface rssx_alu_if;
  logic [2:0] op_code;
  logic [7:0] mem_data;
  logic [7:0] literal;
  logic [7:0] work_in;
  logic carry_in;
  logic chained_zero_in;
  logic legal;
  logic [7:0] result;
  logic wr_work;
  logic wr_mem;
  logic wr_flags;
  logic wr_carry_only;
  logic skip;
  rssx_pkg::rssx_flags_s flags;

  modport exec (output op_code, mem_data, literal, work_in, carry_in, chained_zero_in,
                input legal, result, wr_work, wr_mem, wr_flags, wr_carry_only, skip, flags);
  modport alu (input op_code, mem_data, literal, work_in, carry_in, chained_zero_in,
               output legal, result, wr_work, wr_mem, wr_flags, wr_carry_only, skip, flags);
endinterface

// >>> hw/rssx_alu.sv
`timescale 1ns/1ps
`include "rssx_defs.svh"

module rssx_alu (
  rssx_alu_if.alu alu_bus
);

  // borrow-aware subtract shared by all three subtract forms
  function automatic logic [8:0] rssx_sub9(input logic [7:0] a, input logic [7:0] b, input logic c);
    rssx_sub9 = {1'b0, a} - {1'b0, b} - {8'h00, ~c};
  endfunction

  function automatic logic [4:0] rssx_sub5(input logic [3:0] a, input logic [3:0] b, input logic c);
    rssx_sub5 = {1'b0, a} - {1'b0, b} - {4'h0, ~c};
  endfunction

  logic [7:0] sub_b;
  logic [8:0] diff9;
  logic [4:0] diff5;
  logic [7:0] dec_val;
  logic ovf;

  always_comb begin
    sub_b = (alu_bus.op_code == rssx_pkg::RSSX_OP_SUB_IMM) ? alu_bus.literal : alu_bus.mem_data;
    diff9 = rssx_sub9(alu_bus.work_in, sub_b, alu_bus.carry_in);
    diff5 = rssx_sub5(alu_bus.work_in[`RSSX_NIB_MSB:0], sub_b[`RSSX_NIB_MSB:0], alu_bus.carry_in);
    // wraps modulo 256, so zero goes to all ones and does not skip
    dec_val = alu_bus.mem_data - `RSSX_DEC_STEP;
    ovf = (alu_bus.work_in[`RSSX_BYTE_MSB] != sub_b[`RSSX_BYTE_MSB]) &&
          (diff9[`RSSX_BYTE_MSB] != alu_bus.work_in[`RSSX_BYTE_MSB]);
    alu_bus.legal = 1'b1;
    alu_bus.result = `RSSX_ZERO_BYTE;
    alu_bus.wr_work = 1'b0;
    alu_bus.wr_mem = 1'b0;
    alu_bus.wr_flags = 1'b0;
    alu_bus.wr_carry_only = 1'b0;
    alu_bus.skip = 1'b0;
    alu_bus.flags = '0;
    unique case (alu_bus.op_code)
      rssx_pkg::RSSX_OP_ROTATE: begin
        alu_bus.result = {alu_bus.carry_in, alu_bus.mem_data[`RSSX_BYTE_MSB:1]};
        alu_bus.wr_work = 1'b1;
        alu_bus.wr_carry_only = 1'b1;
        alu_bus.flags.carry_flag = alu_bus.mem_data[0];
      end
      rssx_pkg::RSSX_OP_SUB_MEM, rssx_pkg::RSSX_OP_SUB_IMM, rssx_pkg::RSSX_OP_SUB_TO_MEM: begin
        alu_bus.result = diff9[`RSSX_BYTE_MSB:0];
        alu_bus.wr_work = (alu_bus.op_code != rssx_pkg::RSSX_OP_SUB_TO_MEM);
        alu_bus.wr_mem = (alu_bus.op_code == rssx_pkg::RSSX_OP_SUB_TO_MEM);
        alu_bus.wr_flags = 1'b1;
        alu_bus.flags.carry_flag = ~diff9[8];
        alu_bus.flags.half_carry_flag = ~diff5[4];
        alu_bus.flags.overflow_flag = ovf;
        alu_bus.flags.zero_flag = (diff9[`RSSX_BYTE_MSB:0] == `RSSX_ZERO_BYTE);
        alu_bus.flags.signed_compare_flag = diff9[`RSSX_BYTE_MSB] ^ ovf;
        alu_bus.flags.chained_zero_flag = (diff9[`RSSX_BYTE_MSB:0] == `RSSX_ZERO_BYTE) &&
                                          alu_bus.chained_zero_in;
      end
      rssx_pkg::RSSX_OP_DEC_SKIP, rssx_pkg::RSSX_OP_DEC_SKIP_WORK: begin
        alu_bus.result = dec_val;
        alu_bus.wr_mem = (alu_bus.op_code == rssx_pkg::RSSX_OP_DEC_SKIP);
        alu_bus.wr_work = (alu_bus.op_code == rssx_pkg::RSSX_OP_DEC_SKIP_WORK);
        alu_bus.skip = (dec_val == `RSSX_ZERO_BYTE);
      end
      default: begin
        alu_bus.legal = 1'b0;
      end
    endcase
  end

endmodule // rssx_alu

// >>> hw/rssx_exec.sv
`timescale 1ns/1ps
`include "rssx_defs.svh"

module rssx_exec (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic op_valid,
  input wire logic [2:0] op_code,
  input wire logic [7:0] mem_data,
  input wire logic [7:0] literal,
  input wire logic [7:0] work_in,
  input wire logic carry_in,
  input wire logic chained_zero_in,
  output logic op_ready,
  output logic work_wr_en,
  output logic [7:0] work_wr_data,
  output logic mem_wr_en,
  output logic [7:0] mem_wr_data,
  output logic flags_wr_en,
  output logic carry_wr_en,
  output logic overflow_flag,
  output logic zero_flag,
  output logic half_carry_flag,
  output logic carry_flag,
  output logic signed_compare_flag,
  output logic chained_zero_flag,
  output logic skip_next,
  output logic dummy_cycle
);

  ////////////////////////////////////////////////////////////////////////////////
  // reset release

  logic rst_meta_reg;
  logic rst_meta_next;
  logic rst_sync_reg;
  logic rst_sync_next;

  // two stages so a release close to the edge cannot leave half the flops in reset
  always_comb begin
    rst_meta_next = 1'b1;
    rst_sync_next = rst_meta_reg;
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= rst_meta_next;
      rst_sync_reg <= rst_sync_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // datapath

  rssx_alu_if alu_bus ();

  // operands are on the core clock already, so no synchroniser
  assign alu_bus.op_code = op_code;
  assign alu_bus.mem_data = mem_data;
  assign alu_bus.literal = literal;
  assign alu_bus.work_in = work_in;
  assign alu_bus.carry_in = carry_in;
  assign alu_bus.chained_zero_in = chained_zero_in;

  rssx_alu u_alu (
    .alu_bus(alu_bus.alu)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // sequencing and registered results

  rssx_pkg::rssx_state_e state_reg;
  rssx_pkg::rssx_state_e state_next;
  logic ready_reg;
  logic ready_next;
  logic dummy_reg;
  logic dummy_next;
  logic skip_reg;
  logic skip_next_val;
  logic work_en_reg;
  logic work_en_next;
  logic [7:0] work_data_reg;
  logic [7:0] work_data_next;
  logic mem_en_reg;
  logic mem_en_next;
  logic [7:0] mem_data_reg;
  logic [7:0] mem_data_next;
  logic flags_en_reg;
  logic flags_en_next;
  logic carry_en_reg;
  logic carry_en_next;
  rssx_pkg::rssx_flags_s flags_reg;
  rssx_pkg::rssx_flags_s flags_next;
  logic take;
  logic accept;

  // illegal codes are taken but do nothing, so the core never stalls on them
  always_comb begin
    take = op_valid && ready_reg;
    accept = take && alu_bus.legal;
  end

  // sequencing: a skip turns the following slot into a dummy
  always_comb begin
    state_next = state_reg;
    ready_next = ready_reg;
    dummy_next = 1'b0;
    skip_next_val = 1'b0;
    unique case (state_reg)
      rssx_pkg::RSSX_ST_RUN: begin
        if (accept && alu_bus.skip) begin
          // fetch of the following word is wasted as a dummy slot
          skip_next_val = 1'b1;
          dummy_next = 1'b1;
          ready_next = 1'b0;
          state_next = rssx_pkg::RSSX_ST_DUMMY;
        end else begin
          ready_next = 1'b1;
        end
      end
      rssx_pkg::RSSX_ST_DUMMY: begin
        ready_next = 1'b1;
        state_next = rssx_pkg::RSSX_ST_RUN;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      state_reg <= rssx_pkg::RSSX_ST_RUN;
      ready_reg <= `RSSX_RST_READY;
      dummy_reg <= `RSSX_RST_FLAG;
      skip_reg <= `RSSX_RST_FLAG;
    end else begin
      state_reg <= state_next;
      ready_reg <= ready_next;
      dummy_reg <= dummy_next;
      skip_reg <= skip_next_val;
    end
  end

  // results: enables pulse for one cycle, data and flags hold until the next write
  always_comb begin
    work_en_next = 1'b0;
    mem_en_next = 1'b0;
    flags_en_next = 1'b0;
    carry_en_next = 1'b0;
    work_data_next = work_data_reg;
    mem_data_next = mem_data_reg;
    flags_next = flags_reg;
    // accept needs ready, so nothing lands in the dummy slot
    if (accept) begin
      work_en_next = alu_bus.wr_work;
      mem_en_next = alu_bus.wr_mem;
      flags_en_next = alu_bus.wr_flags;
      carry_en_next = alu_bus.wr_carry_only || alu_bus.wr_flags;
      if (alu_bus.wr_work) begin
        work_data_next = alu_bus.result;
      end
      if (alu_bus.wr_mem) begin
        mem_data_next = alu_bus.result;
      end
      if (alu_bus.wr_flags || alu_bus.wr_carry_only) begin
        flags_next = alu_bus.flags;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      work_en_reg <= `RSSX_RST_FLAG;
      work_data_reg <= `RSSX_RST_BYTE;
      mem_en_reg <= `RSSX_RST_FLAG;
      mem_data_reg <= `RSSX_RST_BYTE;
      flags_en_reg <= `RSSX_RST_FLAG;
      carry_en_reg <= `RSSX_RST_FLAG;
      flags_reg <= '0;
    end else begin
      work_en_reg <= work_en_next;
      work_data_reg <= work_data_next;
      mem_en_reg <= mem_en_next;
      mem_data_reg <= mem_data_next;
      flags_en_reg <= flags_en_next;
      carry_en_reg <= carry_en_next;
      flags_reg <= flags_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // outputs, all straight from flops

  assign op_ready = ready_reg;
  assign dummy_cycle = dummy_reg;
  assign skip_next = skip_reg;
  assign work_wr_en = work_en_reg;
  assign work_wr_data = work_data_reg;
  assign mem_wr_en = mem_en_reg;
  assign mem_wr_data = mem_data_reg;
  assign flags_wr_en = flags_en_reg;
  assign carry_wr_en = carry_en_reg;
  assign overflow_flag = flags_reg.overflow_flag;
  assign zero_flag = flags_reg.zero_flag;
  assign half_carry_flag = flags_reg.half_carry_flag;
  assign carry_flag = flags_reg.carry_flag;
  assign signed_compare_flag = flags_reg.signed_compare_flag;
  assign chained_zero_flag = flags_reg.chained_zero_flag;

endmodule // rssx_exec

// >>> verification/rssx_exec_checker.sv
`timescale 1ns/1ps
module rssx_exec_checker (
  input logic sys_clk,
  input logic reset_n,
  input logic op_valid,
  input logic [2:0] op_code,
  input logic [7:0] mem_data,
  input logic [7:0] literal,
  input logic [7:0] work_in,
  input logic carry_in,
  input logic op_ready,
  input logic work_wr_en,
  input logic [7:0] work_wr_data,
  input logic mem_wr_en,
  input logic [7:0] mem_wr_data,
  input logic flags_wr_en,
  input logic carry_flag,
  input logic zero_flag,
  input logic skip_next,
  input logic dummy_cycle
);
  logic taken;
  logic [7:0] dr, ir, dec;
  logic dc, ic;
  assign taken = op_valid & op_ready;
  // borrow out inverted gives the no-borrow carry
  assign {dc, dr} = {1'b0, work_in} - {1'b0, mem_data} - {8'h00, ~carry_in};
  assign {ic, ir} = {1'b0, work_in} - {1'b0, literal} - {8'h00, ~carry_in};
  assign dec = mem_data - 8'h01;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  ////////////////////////////////////////////////////////////////
  AST_ROT:
  assert property (taken && op_code == 3'h0 |=> work_wr_en && !mem_wr_en
    && work_wr_data == {$past(carry_in), $past(mem_data[7:1])} && carry_flag == $past(mem_data[0]))
    else $error("rotate result wrong");
  AST_SUB_CARRY:
  assert property (taken && op_code inside {3'h1, 3'h3} |=> flags_wr_en && carry_flag == !$past(dc))
    else $error("subtract carry wrong");
  AST_SUB_MEM:
  assert property (taken && op_code == 3'h1 |=> work_wr_en && !mem_wr_en && work_wr_data == $past(dr))
    else $error("subtract from memory wrong");
  AST_SUB_IMM:
  assert property (taken && op_code == 3'h2 |=> work_wr_en && work_wr_data == $past(ir) && carry_flag == !$past(ic))
    else $error("subtract immediate wrong");
  AST_SUB_TO_MEM:
  assert property (taken && op_code == 3'h3 |=> mem_wr_en && !work_wr_en && mem_wr_data == $past(dr))
    else $error("subtract to memory wrong");
  AST_DEC_SKIP:
  assert property (taken && op_code == 3'h4 |=> mem_wr_en && !work_wr_en && !flags_wr_en
    && mem_wr_data == $past(dec) && skip_next == ($past(dec) == 8'h00)) else $error("decrement skip wrong");
  AST_DEC_WORK:
  assert property (taken && op_code == 3'h5 |=> work_wr_en && !mem_wr_en && !flags_wr_en
    && work_wr_data == $past(dec) && skip_next == ($past(dec) == 8'h00)) else $error("decrement to work wrong");
  AST_SKIP_GAP:
  assert property (skip_next |-> dummy_cycle && !op_ready ##1 op_ready && !skip_next)
    else $error("skip cycle wrong");
  AST_NO_SKIP:
  assert property (taken && op_code inside {3'h4, 3'h5} && dec != 8'h00 |=> !skip_next && !dummy_cycle && op_ready)
    else $error("unexpected skip");
  AST_ZERO:
  assert property (flags_wr_en |-> zero_flag == ((work_wr_en ? work_wr_data : mem_wr_data) == 8'h00))
    else $error("zero flag wrong");
  ////////////////////////////////////////////////////////////////
  cover property (skip_next);
  cover property (op_valid && !op_ready);
  cover property (flags_wr_en ##1 flags_wr_en);
endmodule // rssx_exec_checker

bind rssx_exec rssx_exec_checker chk_u (.sys_clk(sys_clk), .reset_n(reset_n), .op_valid(op_valid),
  .op_code(op_code), .mem_data(mem_data), .literal(literal), .work_in(work_in), .carry_in(carry_in),
  .op_ready(op_ready), .work_wr_en(work_wr_en), .work_wr_data(work_wr_data), .mem_wr_en(mem_wr_en),
  .mem_wr_data(mem_wr_data), .flags_wr_en(flags_wr_en), .carry_flag(carry_flag), .zero_flag(zero_flag),
  .skip_next(skip_next), .dummy_cycle(dummy_cycle));

// >>> verification/testbench.sv
`timescale 1ns/1ps
module testbench;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic op_valid = 1'b0;
  logic carry_in = 1'b0;
  logic chained_zero_in = 1'b0;
  logic [2:0] op_code = 3'h0;
  logic [7:0] mem_data = 8'h00, literal = 8'h00, work_in = 8'h00;
  logic op_ready, work_wr_en, mem_wr_en, flags_wr_en, carry_wr_en, skip_next, dummy_cycle;
  logic overflow_flag, zero_flag, half_carry_flag, carry_flag, signed_compare_flag, chained_zero_flag;
  logic [7:0] work_wr_data, mem_wr_data;
  logic [14:0] rst_view;
  int bad_count = 0;
  int n_checks = 0;
  // {op, mem, literal, work, carry, chained zero, expected result}
  logic [36:0] rows [10] = '{{3'h0, 8'h81, 8'hff, 8'h00, 1'b0, 1'b0, 8'h40},
    {3'h0, 8'h02, 8'hff, 8'h00, 1'b1, 1'b0, 8'h81}, {3'h1, 8'h01, 8'hff, 8'h10, 1'b1, 1'b0, 8'h0f},
    {3'h1, 8'h00, 8'hff, 8'h00, 1'b0, 1'b1, 8'hff}, {3'h2, 8'hff, 8'h01, 8'h80, 1'b1, 1'b0, 8'h7f},
    {3'h3, 8'h05, 8'hff, 8'h05, 1'b1, 1'b1, 8'h00}, {3'h4, 8'h01, 8'hff, 8'h00, 1'b0, 1'b0, 8'h00},
    {3'h4, 8'h00, 8'hff, 8'h00, 1'b0, 1'b0, 8'hff}, {3'h5, 8'h01, 8'hff, 8'h00, 1'b0, 1'b0, 8'h00},
    {3'h5, 8'h80, 8'hff, 8'h00, 1'b0, 1'b0, 8'h7f}};
  always #4 sys_clk = ~sys_clk;
  assign rst_view = {op_ready, work_wr_en, mem_wr_en, flags_wr_en, carry_wr_en, skip_next, dummy_cycle, work_wr_data};
  rssx_exec dut_u (.sys_clk(sys_clk), .reset_n(reset_n), .op_valid(op_valid), .op_code(op_code),
    .mem_data(mem_data), .literal(literal), .work_in(work_in), .carry_in(carry_in),
    .chained_zero_in(chained_zero_in), .op_ready(op_ready), .work_wr_en(work_wr_en),
    .work_wr_data(work_wr_data), .mem_wr_en(mem_wr_en), .mem_wr_data(mem_wr_data), .flags_wr_en(flags_wr_en),
    .carry_wr_en(carry_wr_en), .overflow_flag(overflow_flag), .zero_flag(zero_flag),
    .half_carry_flag(half_carry_flag), .carry_flag(carry_flag), .signed_compare_flag(signed_compare_flag),
    .chained_zero_flag(chained_zero_flag), .skip_next(skip_next), .dummy_cycle(dummy_cycle));
  ////////////////////////////////////////////////////////////////
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task test_done;
    $display("checks=%0d errors=%0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task drive(input logic [36:0] r);
    @(posedge sys_clk);
    op_valid <= 1'b1;
    {op_code, mem_data, literal, work_in, carry_in, chained_zero_in} <= r[36:8];
  endtask
  task idle;
    @(posedge sys_clk);
    op_valid <= 1'b0;
  endtask
  // flags worked out independently: carry and half carry mean no borrow
  task check_row(input logic [36:0] r);
    logic [2:0] op;
    logic [7:0] w, m, q;
    logic [8:0] d;
    logic [4:0] h;
    logic ov, skp;
    logic [5:0] fl, ef;
    #1;
    op = r[36:34];
    w = r[17:10];
    m = (op == 3'h2) ? r[25:18] : r[33:26];
    skp = (op >= 3'h4) && r[7:0] == 8'h00;
    d = {1'b0, w} - {1'b0, m} - {8'h00, ~r[9]};
    h = {1'b0, w[3:0]} - {1'b0, m[3:0]} - {4'h0, ~r[9]};
    q = d[7:0];
    ov = (w[7] ^ m[7]) & (q[7] ^ w[7]);
    chk(work_wr_en, op inside {3'h0, 3'h1, 3'h2, 3'h5});
    chk(mem_wr_en, op inside {3'h3, 3'h4});
    chk(work_wr_en ? work_wr_data : mem_wr_data, r[7:0]);
    chk({skip_next, dummy_cycle, op_ready}, {skp, skp, ~skp});
    chk({flags_wr_en, carry_wr_en}, {(op inside {3'h1, 3'h2, 3'h3}), (op <= 3'h3)});
    if (op == 3'h0) chk(carry_flag, r[26]);
    ef = {ov, (q == 8'h00), ~h[4], ~d[8], q[7] ^ ov, ((q == 8'h00) && r[8])};
    fl = {overflow_flag, zero_flag, half_carry_flag, carry_flag, signed_compare_flag, chained_zero_flag};
    if (op inside {3'h1, 3'h2, 3'h3}) chk(fl, ef);
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (400) @(posedge sys_clk);
    bad_count++;
    test_done;
  end
  initial begin
    repeat (16) @(posedge sys_clk);
    #1 chk(rst_view, 16'h4000);
    @(posedge sys_clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
    for (int i = 0; i < 10; i++) begin
      drive(rows[i]);
      idle;
      check_row(rows[i]);
    end
    // back to back subtracts with no gap
    drive(rows[2]);
    drive(rows[4]);
    check_row(rows[2]);
    idle;
    check_row(rows[4]);
    // a rotate offered in the dummy cycle must be ignored
    drive(rows[6]);
    drive(rows[0]);
    check_row(rows[6]);
    idle;
    #1 chk({work_wr_en, carry_wr_en}, 16'h0000);
    // an unused code is taken and does nothing
    drive({3'h6, 8'h01, 8'hff, 8'h00, 1'b0, 1'b0, 8'h00});
    idle;
    #1 chk({work_wr_en, mem_wr_en, flags_wr_en, carry_wr_en, skip_next, dummy_cycle, op_ready}, 16'h0001);
    // reset in mid-run clears data written before it
    drive(rows[9]);
    idle;
    check_row(rows[9]);
    @(posedge sys_clk);
    reset_n <= 1'b0;
    #1 chk(rst_view, 16'h4000);
    repeat (2) @(posedge sys_clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
    drive(rows[1]);
    idle;
    check_row(rows[1]);
    idle;
    test_done;
  end
endmodule // testbench
